// [design/sdqba_device.sv]
// How it works
// - all inputs taken on rising clock edge
// - activate: two bank bits, twelve row bits
// - column bits: ten, nine or eight
// - bursts of 1,2,4,8 or page, ordered
// - burst terminate stops further burst words
// - auto precharge closes row at the end of a 1,2,4 or 8 burst; page or terminated bursts leave it open
// - new column each cycle, no stall
// - 4096 refreshes every 64 ms, half that rate in low-power self refresh
// - 4096 rows, columns sized by organisation
// - controller precharges all banks at start-up, then closes rows by auto precharge
// - read data after two or three cycles
// - self refresh, standard or low power
`default_nettype none
module sdqba_device #(
    parameter int DQ_W         = 16,
    parameter int MEM_ROW_BITS = 4,
    parameter bit LOW_POWER    = 1'b0
) (
    input  wire logic                              clk_sys,
    input  wire logic                              srst,
    sdqba_if.dev                                   link,
    output logic                                   self_refresh_active,
    output logic [sdqba_pkg::BANK_N-1:0]           bank_open,
    output logic [sdqba_pkg::ROW_W-1:0]            refresh_row
);
    import sdqba_pkg::*;

    localparam int COL_W = col_width(DQ_W);
    localparam int IDX_W = 2 + MEM_ROW_BITS + COL_W;
    // low-power variant refreshes itself at half the rate
    localparam int SR_INT = LOW_POWER ? 2 * REF_INT_CYC : REF_INT_CYC;

    generate
        if (!(DQ_W == 4 || DQ_W == 8 || DQ_W == 16) ||
            MEM_ROW_BITS < 1 || MEM_ROW_BITS > ROW_W) begin : g_bad_cfg
            $error("sdqba_device: unsupported organisation");
        end
    endgenerate

    // only the low row bits are backed by storage, to keep the model small
    logic [DQ_W-1:0]  mem [2**IDX_W];

    logic [3:0]       cmd;
    logic [1:0]       ba;
    logic             live;
    logic             is_act;
    logic             is_rd;
    logic             is_wr;
    logic             is_pre;
    logic             is_bst;
    logic             is_ref;
    logic             is_lmr;
    logic             new_col;
    logic             pre_kill;

    logic [2:0]       bl_ff;
    logic             bt_ff;
    logic [2:0]       lat_ff;
    logic [COL_W-1:0] mask;

    logic [BANK_N-1:0] bank_open_ff;
    logic [ROW_W-1:0]  row_ff [BANK_N];

    logic             bact_ff;
    logic             bwr_ff;
    logic             bap_ff;
    logic [1:0]       bbank_ff;
    logic [COL_W-1:0] bstart_ff;
    logic [COL_W-1:0] bcnt_ff;

    logic             acc_go;
    logic             acc_wr;
    logic             acc_ap;
    logic             acc_last;
    logic [1:0]       acc_bank;
    logic [COL_W-1:0] acc_start;
    logic [COL_W-1:0] acc_cnt;
    logic [COL_W-1:0] acc_off;
    logic [COL_W-1:0] acc_col;
    logic [ROW_W-1:0] acc_row;
    logic [IDX_W-1:0] idx;

    logic [DQ_W-1:0]  pipe_ff [3];
    logic [2:0]       pv_ff;

    logic             sr_ff;
    logic [15:0]      sr_tmr_ff;
    logic [ROW_W-1:0] ref_row_ff;

    // command decode; a deselected or suspended cycle is ignored
    assign cmd      = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    assign ba       = {link.bank_select_high, link.bank_select_low};
    assign live     = link.cke && !sr_ff && !link.cs_n;
    assign is_act   = live && (cmd == CMD_ACT);
    assign is_rd    = live && (cmd == CMD_RD);
    assign is_wr    = live && (cmd == CMD_WR);
    assign is_pre   = live && (cmd == CMD_PRE);
    assign is_bst   = live && (cmd == CMD_BST);
    assign is_ref   = live && (cmd == CMD_REF);
    assign is_lmr   = live && (cmd == CMD_LMR);
    assign new_col  = is_rd || is_wr;
    // precharging the bursting bank also ends the burst
    assign pre_kill = is_pre && (link.addr[AP_BIT] || ba == bbank_ff);

    // burst length as a wrap mask inside an aligned block
    always_comb begin
        case (bl_ff)
            BL_1:    mask = '0;
            BL_2:    mask = COL_W'(1);
            BL_4:    mask = COL_W'(3);
            BL_8:    mask = COL_W'(7);
            default: mask = '1;
        endcase
    end

    // mode word, loaded from the address lines
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bl_ff  <= MR_RST_BL;
            bt_ff  <= MR_RST_BT;
            lat_ff <= MR_RST_LAT;
        end else if (is_lmr) begin
            bl_ff  <= link.addr[MR_BL_LSB +: 3];
            bt_ff  <= link.addr[MR_BT_BIT];
            lat_ff <= link.addr[MR_LAT_LSB +: 3];
        end
    end

    // the column touched this cycle: fresh command beats running burst
    always_comb begin
        acc_go    = new_col || (bact_ff && !is_bst && !pre_kill);
        acc_start = new_col ? link.addr[COL_W-1:0] : bstart_ff;
        acc_cnt   = new_col ? '0 : bcnt_ff;
        acc_bank  = new_col ? ba : bbank_ff;
        acc_wr    = new_col ? is_wr : bwr_ff;
        acc_ap    = new_col ? link.addr[AP_BIT] : bap_ff;
        // a page burst wraps round the row until terminated
        acc_last  = (bl_ff != BL_PAGE) && (acc_cnt == mask);
        acc_off   = bt_ff ? (acc_start ^ acc_cnt)
                          : COL_W'(acc_start + acc_cnt);
        acc_col   = (acc_start & ~mask) | (acc_off & mask);
        acc_row   = row_ff[acc_bank];
        idx       = {acc_bank, acc_row[MEM_ROW_BITS-1:0], acc_col};
    end

    // burst sequencer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bact_ff   <= 1'b0;
            bwr_ff    <= 1'b0;
            bap_ff    <= 1'b0;
            bbank_ff  <= 2'h0;
            bstart_ff <= '0;
            bcnt_ff   <= '0;
        end else if (new_col) begin
            bact_ff   <= !acc_last;
            bwr_ff    <= is_wr;
            bap_ff    <= link.addr[AP_BIT];
            bbank_ff  <= ba;
            bstart_ff <= link.addr[COL_W-1:0];
            bcnt_ff   <= COL_W'(1);
        end else if (is_bst || pre_kill) begin
            bact_ff   <= 1'b0;
        end else if (bact_ff) begin
            bcnt_ff   <= COL_W'(bcnt_ff + COL_W'(1));
            if (acc_last) begin
                bact_ff <= 1'b0;
            end
        end
    end

    // open-row bookkeeping per bank
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bank_open_ff <= '0;
        end else begin
            if (acc_go && acc_last && acc_ap) begin
                bank_open_ff[acc_bank] <= 1'b0;
            end
            if (is_pre) begin
                if (link.addr[AP_BIT]) begin
                    bank_open_ff <= '0;
                end else begin
                    bank_open_ff[ba] <= 1'b0;
                end
            end
            if (is_act) begin
                bank_open_ff[ba] <= 1'b1;
            end
        end
    end

    // row latched per bank on activate
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int b = 0; b < BANK_N; b++) begin
                row_ff[b] <= '0;
            end
        end else if (is_act) begin
            row_ff[ba] <= link.addr;
        end
    end

    // storage write: data is taken on the same edge as its column
    always_ff @(posedge clk_sys) begin
        if (acc_go && acc_wr && bank_open_ff[acc_bank]) begin
            mem[idx] <= link.dq;
        end
    end

    // read pipeline; its depth sets the read latency
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pv_ff <= 3'h0;
            for (int s = 0; s < 3; s++) begin
                pipe_ff[s] <= '0;
            end
        end else begin
            pv_ff      <= {pv_ff[1:0], acc_go && !acc_wr};
            pipe_ff[0] <= mem[idx];
            pipe_ff[1] <= pipe_ff[0];
            pipe_ff[2] <= pipe_ff[1];
        end
    end

    // stage one leaves after two edges, stage two after three
    assign link.dev_dq_o  = (lat_ff == LAT_2) ? pipe_ff[1] : pipe_ff[2];
    assign link.dev_dq_oe = (lat_ff == LAT_2) ? pv_ff[1] : pv_ff[2];

    // self refresh: entered by a refresh with clock enable low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sr_ff <= 1'b0;
        end else if (!sr_ff) begin
            if (!link.cs_n && cmd == CMD_REF && !link.cke) begin
                sr_ff <= 1'b1;
            end
        end else if (link.cke) begin
            sr_ff <= 1'b0;
        end
    end

    // internal refresh row counter, advanced by both refresh kinds
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ref_row_ff <= '0;
            sr_tmr_ff  <= 16'h0000;
        end else if (sr_ff) begin
            if (sr_tmr_ff == 16'(SR_INT - 1)) begin
                sr_tmr_ff  <= 16'h0000;
                ref_row_ff <= ROW_W'(ref_row_ff + ROW_W'(1));
            end else begin
                sr_tmr_ff  <= 16'(sr_tmr_ff + 16'h0001);
            end
        end else begin
            sr_tmr_ff <= 16'h0000;
            if (is_ref) begin
                ref_row_ff <= ROW_W'(ref_row_ff + ROW_W'(1));
            end
        end
    end

    assign self_refresh_active = sr_ff;
    assign bank_open           = bank_open_ff;
    assign refresh_row         = ref_row_ff;
endmodule
`default_nettype wire

// [design/sdqba_host.sv]
`default_nettype none
module sdqba_host #(
    parameter int DQ_W    = 16,
    parameter int CAS_LAT = 3
) (
    input  wire logic                              clk_sys,
    input  wire logic                              srst,
    sdqba_if.host                                  link,
    input  wire logic                              req_valid,
    output logic                                   req_ready,
    input  wire logic                              req_write,
    input  wire logic [1:0]                        req_bank,
    input  wire logic [sdqba_pkg::ROW_W-1:0]       req_row,
    input  wire logic [sdqba_pkg::COL_MAX_W-1:0]   req_col,
    input  wire logic [DQ_W-1:0]                   req_wdata,
    output logic                                   rsp_valid,
    output logic [DQ_W-1:0]                        rsp_rdata,
    input  wire logic                              sleep_req,
    output logic                                   init_done
);
    import sdqba_pkg::*;

    generate
        if (CAS_LAT != 2 && CAS_LAT != 3) begin : g_bad_lat
            $error("sdqba_host: read latency must be 2 or 3");
        end
    endgenerate

    typedef enum logic [2:0] {
        HS_INIT_PRE, HS_INIT_REF, HS_INIT_LMR, HS_IDLE,
        HS_COL, HS_READ_WAIT, HS_SLEEP
    } sdqba_hstate_t;

    sdqba_hstate_t          state_ff;
    logic [3:0]             cmd_ff;
    logic [1:0]             ba_ff;
    logic [ROW_W-1:0]       addr_ff;
    logic                   cke_ff;
    logic [DQ_W-1:0]        dq_ff;
    logic                   dq_oe_ff;
    logic [2:0]             wait_ff;
    logic [1:0]             irefs_ff;
    logic                   wr_ff;
    logic [COL_MAX_W-1:0]   col_ff;
    logic [DQ_W-1:0]        wdata_ff;
    logic [15:0]            ref_tmr_ff;
    logic                   ref_due_ff;
    logic                   ref_set;
    logic                   ref_clr;
    logic                   rsp_valid_ff;
    logic [DQ_W-1:0]        rsp_rdata_ff;
    logic                   can_issue;

    assign can_issue = (wait_ff == 3'h0);
    assign ref_set   = (ref_tmr_ff == 16'(REF_INT_CYC - 1));
    assign ref_clr   = (state_ff == HS_IDLE) && can_issue && ref_due_ff;
    assign req_ready = (state_ff == HS_IDLE) && can_issue &&
                       !sleep_req && !ref_due_ff;

    // refresh pacing; a new tick wins over the clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ref_tmr_ff <= 16'h0000;
            ref_due_ff <= 1'b0;
        end else begin
            ref_tmr_ff <= ref_set ? 16'h0000 : 16'(ref_tmr_ff + 16'h0001);
            ref_due_ff <= ref_set || (ref_due_ff && !ref_clr);
        end
    end

    // command sequencer; every command is a one-cycle pulse
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff     <= HS_INIT_PRE;
            cmd_ff       <= CMD_NOP;
            ba_ff        <= 2'h0;
            addr_ff      <= '0;
            cke_ff       <= 1'b1;
            dq_ff        <= '0;
            dq_oe_ff     <= 1'b0;
            wait_ff      <= 3'h0;
            irefs_ff     <= 2'h0;
            wr_ff        <= 1'b0;
            col_ff       <= '0;
            wdata_ff     <= '0;
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= '0;
        end else begin
            cmd_ff       <= CMD_NOP;
            dq_oe_ff     <= 1'b0;
            rsp_valid_ff <= 1'b0;
            if (!can_issue) begin
                wait_ff <= 3'(wait_ff - 3'h1);
            end
            case (state_ff)
                HS_INIT_PRE: if (can_issue) begin
                    cmd_ff           <= CMD_PRE;
                    addr_ff          <= '0;
                    addr_ff[AP_BIT]  <= 1'b1;
                    irefs_ff         <= 2'(INIT_REF_N);
                    wait_ff          <= 3'(CMD_GAP_CYC);
                    state_ff         <= HS_INIT_REF;
                end
                HS_INIT_REF: if (can_issue) begin
                    cmd_ff   <= CMD_REF;
                    irefs_ff <= 2'(irefs_ff - 2'h1);
                    wait_ff  <= 3'(CMD_GAP_CYC);
                    if (irefs_ff == 2'h1) begin
                        state_ff <= HS_INIT_LMR;
                    end
                end
                HS_INIT_LMR: if (can_issue) begin
                    cmd_ff                   <= CMD_LMR;
                    addr_ff                  <= '0;
                    addr_ff[MR_BL_LSB +: 3]  <= BL_1;
                    addr_ff[MR_LAT_LSB +: 3] <= 3'(CAS_LAT);
                    wait_ff                  <= 3'(CMD_GAP_CYC);
                    state_ff                 <= HS_IDLE;
                end
                HS_IDLE: if (can_issue) begin
                    if (sleep_req) begin
                        cmd_ff   <= CMD_REF;
                        cke_ff   <= 1'b0;
                        state_ff <= HS_SLEEP;
                    end else if (ref_due_ff) begin
                        cmd_ff  <= CMD_REF;
                        wait_ff <= 3'(CMD_GAP_CYC);
                    end else if (req_valid) begin
                        cmd_ff   <= CMD_ACT;
                        ba_ff    <= req_bank;
                        addr_ff  <= req_row;
                        wr_ff    <= req_write;
                        col_ff   <= req_col;
                        wdata_ff <= req_wdata;
                        wait_ff  <= 3'(CMD_GAP_CYC);
                        state_ff <= HS_COL;
                    end
                end
                HS_COL: if (can_issue) begin
                    // auto precharge closes the row, so the next access
                    // may open any row of any bank without a precharge
                    cmd_ff          <= wr_ff ? CMD_WR : CMD_RD;
                    addr_ff         <= ROW_W'(col_ff);
                    addr_ff[AP_BIT] <= 1'b1;
                    dq_ff           <= wdata_ff;
                    dq_oe_ff        <= wr_ff;
                    if (wr_ff) begin
                        wait_ff  <= 3'(CMD_GAP_CYC);
                        state_ff <= HS_IDLE;
                    end else begin
                        wait_ff  <= 3'(CAS_LAT + 1);
                        state_ff <= HS_READ_WAIT;
                    end
                end
                HS_READ_WAIT: if (wait_ff == 3'h1) begin
                    rsp_valid_ff <= 1'b1;
                    rsp_rdata_ff <= link.dq;
                    state_ff     <= HS_IDLE;
                end
                HS_SLEEP: if (!sleep_req) begin
                    cke_ff   <= 1'b1;
                    wait_ff  <= 3'(CMD_GAP_CYC);
                    state_ff <= HS_IDLE;
                end
                default: state_ff <= HS_INIT_PRE;
            endcase
        end
    end

    assign link.cke              = cke_ff;
    assign link.cs_n             = cmd_ff[3];
    assign link.ras_n            = cmd_ff[2];
    assign link.cas_n            = cmd_ff[1];
    assign link.we_n             = cmd_ff[0];
    assign link.bank_select_low  = ba_ff[0];
    assign link.bank_select_high = ba_ff[1];
    assign link.addr             = addr_ff;
    assign link.host_dq_o        = dq_ff;
    assign link.host_dq_oe       = dq_oe_ff;
    assign rsp_valid             = rsp_valid_ff;
    assign rsp_rdata             = rsp_rdata_ff;
    assign init_done             = (state_ff != HS_INIT_PRE) &&
                                   (state_ff != HS_INIT_REF) &&
                                   (state_ff != HS_INIT_LMR);
endmodule
`default_nettype wire

// [design/sdqba_if.sv]
`default_nettype none
interface sdqba_if #(parameter int DQ_W = 16);
    var logic                           cke;
    var logic                           cs_n;
    var logic                           ras_n;
    var logic                           cas_n;
    var logic                           we_n;
    var logic                           bank_select_low;
    var logic                           bank_select_high;
    var logic [sdqba_pkg::ROW_W-1:0]    addr;
    var logic [DQ_W-1:0]                host_dq_o;
    var logic                           host_dq_oe;
    var logic [DQ_W-1:0]                dev_dq_o;
    var logic                           dev_dq_oe;
    logic     [DQ_W-1:0]                dq;

    // shared data wire; undriven reads as zero
    assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : '0);

    modport dev (
        input  cke, cs_n, ras_n, cas_n, we_n,
        input  bank_select_low, bank_select_high, addr, dq,
        output dev_dq_o, dev_dq_oe
    );
    modport host (
        output cke, cs_n, ras_n, cas_n, we_n,
        output bank_select_low, bank_select_high, addr,
        output host_dq_o, host_dq_oe,
        input  dq
    );
endinterface
`default_nettype wire

// [design/sdqba_pkg.sv]
`default_nettype none
package sdqba_pkg;
    // array shape
    localparam int BANK_N     = 4;
    localparam int ROW_W      = 12;
    localparam int COL_MAX_W  = 10;
    // command word {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_RD  = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    // address bit that means auto precharge / all banks
    localparam int AP_BIT     = 10;
    // mode word fields, carried on the address lines
    localparam int MR_BL_LSB  = 0;
    localparam int MR_BT_BIT  = 3;
    localparam int MR_LAT_LSB = 4;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] LAT_2   = 3'h2;
    localparam logic [2:0] LAT_3   = 3'h3;
    // mode reset values
    localparam logic [2:0] MR_RST_BL  = BL_1;
    localparam logic       MR_RST_BT  = 1'b0;
    localparam logic [2:0] MR_RST_LAT = LAT_3;
    // refresh timing at the 100 ns system clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int REF_PERIOD_MS = 64;
    localparam int REF_ROWS      = 4096;
    // longest spacing of refreshes, rounded down
    localparam int REF_INT_CYC   =
        (REF_PERIOD_MS * 1000000) / (REF_ROWS * CLK_PERIOD_NS);
    // idle cycles the controller leaves after each command
    localparam int CMD_GAP_CYC   = 1;
    localparam int INIT_REF_N    = 2;

    // column bits per organisation
    function automatic int col_width(input int dq_w);
        col_width = (dq_w == 4) ? 10 : (dq_w == 8) ? 9 : 8;
    endfunction
endpackage
`default_nettype wire

// [verification/sdqba_monitor.sv]
`default_nettype none
module sdqba_monitor (
    input wire logic                          clk_sys,
    input wire logic                          srst,
    input wire logic                          cke,
    input wire logic                          cs_n,
    input wire logic                          ras_n,
    input wire logic                          cas_n,
    input wire logic                          we_n,
    input wire logic                          bank_select_low,
    input wire logic                          bank_select_high,
    input wire logic [sdqba_pkg::ROW_W-1:0]   addr,
    input wire logic                          host_dq_oe,
    input wire logic                          dev_dq_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    import sdqba_pkg::*;
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [8:0] ref_gap_ff;
    // slack for an access still in flight when a refresh falls due
    localparam int REF_SLACK = 20;
    assign cmd  = {cs_n, ras_n, cas_n, we_n};
    assign bank = {bank_select_high, bank_select_low};
    // cycles since the last refresh; self refresh restarts the count
    always_ff @(posedge clk_sys) begin
        if (srst || !cke || cmd == CMD_REF) begin
            ref_gap_ff <= '0;
        end else begin
            ref_gap_ff <= ref_gap_ff + 9'h001;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_cmd; !cs_n && cmd != CMD_NOP; endsequence
    sequence s_rd; cke && cmd == CMD_RD; endsequence
    sequence s_rw; cke && (cmd == CMD_RD || cmd == CMD_WR); endsequence
    sequence s_word; ##2 !dev_dq_oe ##1 dev_dq_oe; endsequence
    a_cmd_gap: assert property (s_cmd |=> cmd == CMD_NOP)
        else $error("command not followed by an idle cycle");
    a_wdata_with_wr: assert property (host_dq_oe == (cmd == CMD_WR))
        else $error("host data drive not aligned with write");
    a_no_clash: assert property (!(dev_dq_oe && host_dq_oe))
        else $error("both ends drive the data wire");
    a_read_latency: assert property (s_rd |-> s_word)
        else $error("read data not three cycles after read");
    a_data_cause: assert property (
        $rose(dev_dq_oe) |-> $past(cmd, 3) == CMD_RD)
        else $error("device drove data without a read");
    a_burst_one: assert property (dev_dq_oe |=> !dev_dq_oe)
        else $error("single burst lasted more than one word");
    a_act_first: assert property (
        s_rw |-> $past(cmd, 2) == CMD_ACT && $past(bank, 2) == bank)
        else $error("access without activate of its bank");
    a_auto_pre: assert property (s_rw |-> addr[AP_BIT])
        else $error("access without auto precharge");
    a_refresh_due: assert property (
        ref_gap_ff < REF_INT_CYC + REF_SLACK)
        else $error("refresh spacing too long");
endmodule
`default_nettype wire

// [verification/tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sdqba_pkg::*;
    localparam int LAT = 3;
    logic        clk_sys, srst, req_valid, req_write, sleep_req;
    logic        req_ready, rsp_valid, init_done, self_refresh_active;
    logic [1:0]  req_bank;
    logic [11:0] req_row, refresh_row, r0, d;
    logic [9:0]  req_col;
    logic [15:0] req_wdata, rsp_rdata, got;
    logic [3:0]  bank_open;
    int          num_errors = 0, check_count = 0, lat, n;
    sdqba_if #(.DQ_W(16)) link_if ();
    sdqba_device #(.DQ_W(16), .MEM_ROW_BITS(4), .LOW_POWER(1'b0))
        sdqba_device_inst (.clk_sys(clk_sys), .srst(srst), .link(link_if),
        .self_refresh_active(self_refresh_active), .bank_open(bank_open),
        .refresh_row(refresh_row));
    sdqba_host #(.DQ_W(16), .CAS_LAT(LAT)) sdqba_host_inst (
        .clk_sys(clk_sys), .srst(srst), .link(link_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .sleep_req(sleep_req), .init_done(init_done));
    sdqba_monitor sdqba_monitor_inst (.clk_sys(clk_sys), .srst(srst),
        .cke(link_if.cke), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n),
        .cas_n(link_if.cas_n), .we_n(link_if.we_n),
        .bank_select_low(link_if.bank_select_low),
        .bank_select_high(link_if.bank_select_high), .addr(link_if.addr),
        .host_dq_oe(link_if.host_dq_oe), .dev_dq_oe(link_if.dev_dq_oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // sampled at falling edges so combinational ready has settled
    task automatic wait_for(ref logic sig, input logic lvl, output int k);
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (sig !== lvl && k < 2000);
        if (sig !== lvl) begin
            num_errors++;
            close_out();
        end
    endtask
    // one request; a read leaves its word in got and its delay in lat
    task automatic access(input logic wr, input logic [1:0] b,
        input logic [11:0] r, input logic [15:0] wd);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= wr;
        req_bank  <= b;
        req_row   <= r;
        req_col   <= 10'h0ff;
        req_wdata <= wd;
        wait_for(req_ready, 1'b1, n);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        if (wr) begin
            repeat (4) @(posedge clk_sys);
        end else begin
            wait_for(rsp_valid, 1'b1, lat);
            got = rsp_rdata;
        end
    endtask
    task automatic t_reset();
        @(negedge clk_sys);
        check(init_done, 1'b0);
        check(bank_open, 4'h0);
        wait_for(init_done, 1'b1, n);
        $display("test reset done");
    endtask
    task automatic t_banks();
        logic [15:0] dv [3] = '{16'h1111, 16'h2222, 16'hc3a5};
        logic [1:0]  bv [3] = '{2'h0, 2'h3, 2'h0};
        logic [11:0] rv [3] = '{12'h001, 12'h001, 12'h00e};
        for (int i = 0; i < 3; i++) access(1'b1, bv[i], rv[i], dv[i]);
        for (int i = 0; i < 3; i++) begin
            access(1'b0, bv[i], rv[i], 16'h0000);
            check(got, dv[i]);
            check(lat, LAT + 4);
            @(negedge clk_sys);
            check(rsp_valid, 1'b0);
            check(bank_open, 4'h0);
        end
        $display("test banks done");
    endtask
    task automatic t_refresh(input logic sleep);
        // idle or asleep, the row counter must keep walking
        // inputs change just after a rising edge; r0 is read settled
        @(posedge clk_sys);
        sleep_req <= sleep;
        wait_for(self_refresh_active, sleep, n);
        check(req_ready & sleep, 1'b0);
        r0 = refresh_row;
        repeat (2 * REF_INT_CYC + 40) @(negedge clk_sys);
        d = refresh_row - r0;
        check(d >= 12'h002 && d <= 12'h003, 1'b1);
        @(posedge clk_sys);
        sleep_req <= 1'b0;
        wait_for(self_refresh_active, 1'b0, n);
        access(1'b0, 2'h3, 12'h001, 16'h0000);
        check(got, 16'h2222);
        $display("test refresh done");
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        {srst, req_valid, req_write, sleep_req} = 4'h8;
        {req_bank, req_row, req_col, req_wdata} = '0;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_banks();
        t_refresh(1'b0);
        t_refresh(1'b1);
        close_out();
    end
endmodule
`default_nettype wire
